// >>> rtl/isq_pkg.sv
`default_nettype none

package isq_pkg;

    // ************************************************************
    // Instruction classes and sequencer states
    // ************************************************************
    typedef enum logic [2:0] {
        OP_DATA,
        OP_PSR,
        OP_BRANCH,
        OP_EXCH,
        OP_LBL_HI,
        OP_LBL_LO
    } isq_op_t;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_DATA,
        ST_BR1,
        ST_BR2,
        ST_BR3,
        ST_SH1,
        ST_SH2,
        ST_SHPC
    } isq_state_t;

    // ************************************************************
    // Widths, lengths and access size codes
    // ************************************************************
    localparam int          ADDR_W     = 32;
    localparam int          SHIFT_W    = 8;
    localparam logic [31:0] LEN_WORD   = 32'h0000_0004;
    localparam logic [31:0] LEN_HALF   = 32'h0000_0002;
    localparam logic [1:0]  SIZE_WORD  = 2'h2;
    localparam logic [1:0]  SIZE_HALF  = 2'h1;

endpackage

`default_nettype wire

// >>> rtl/isq_sequencer.sv
// Overview of operation
// - Request and sequential outputs announce the type of the following bus cycle.
// - Address, size, direction, fetch, translate and state flag apply to their cycle.
// - Prefetch addresses step by 4 bytes, or 2 in compact state.
// - Fetch size code is 2 (word), or 1 (halfword) in compact state.
// - Branch cycle one computes target and still prefetches pc plus twice length.
// - Branch cycle two fetches target; linked branch writes return address to link.
// - Branch cycle three fetches target plus length; linked branch subtracts length.
// - Branch cycles read, fetch opcodes; sequential low in cycle one, high after.
// - First half of compact long link takes one cycle, link gets pc plus offset.
// - Compact long link fetches pc+4, pc+6, target, target+2; sequential 1,0,1,1.
// - Last compact long link cycle fetches target plus 2, link reduced by 2.
// - Exchange branch takes three cycles; first takes target, state, prefetches pc plus twice length.
// - Exchange then fetches target and target plus new length in new width.
// - State flag 0 word state, 1 compact; exchange shows new state from cycle two.
// - Plain data operation is one cycle, prefetch with request active, sequential high.
// - Compare and test ops update flags only, never write a destination.
// - Register shift first copies low 8 bits to latch; next cycle is internal.
// - Writing pc flushes pipeline (except register shift in compact state), next fetch from result, refills before executing.
// - No exception is taken while the pipeline refills after a pc write.
// - Status transfers time like data ops and never use pc.
// - Register shift writing pc, word state only: pc+8, pc+12, target, target+4.
`timescale 1ns/10ps
`default_nettype none

module isq_sequencer (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        op_valid,
    input  wire logic [2:0]  op_class,
    input  wire logic        op_link,
    input  wire logic        op_shift_reg,
    input  wire logic        op_writes_pc,
    input  wire logic        op_compare,
    input  wire logic [31:0] op_pc,
    input  wire logic [31:0] op_alu,
    input  wire logic [31:0] op_offset,
    input  wire logic [31:0] shift_src,
    input  wire logic        translate_in,
    output logic             op_ready,
    output logic [31:0]      addr,
    output logic [1:0]       access_size,
    output logic             write_not_read,
    output logic             instr_fetch_n,
    output logic             translate_user_n,
    output logic             compact_state_flag,
    output logic             mem_request_n,
    output logic             sequential_next,
    output logic [31:0]      link_register,
    output logic [7:0]       shift_amount,
    output logic             result_write_en,
    output logic             pipe_flush,
    output logic             exc_lockout
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] instr_len(input logic compact);
        instr_len = compact ? isq_pkg::LEN_HALF : isq_pkg::LEN_WORD;
    endfunction

    function automatic logic [1:0] fetch_size(input logic compact);
        fetch_size = compact ? isq_pkg::SIZE_HALF : isq_pkg::SIZE_WORD;
    endfunction

    isq_pkg::isq_state_t state;
    isq_pkg::isq_state_t next_state;
    isq_pkg::isq_op_t    cls_q;
    logic [31:0]         pc_q;
    logic [31:0]         tgt_q;
    logic [31:0]         off_q;
    logic                link_q;
    logic                exch_q;
    logic                shpc_q;
    logic                cmp_q;
    logic                compact_instr_state;
    logic                take;
    logic                is_branch;
    logic                wpc;
    logic                next_compact;
    logic [31:0]         next_addr;
    logic                next_fetch_n;
    logic                next_request_n;
    logic                next_sequential;
    logic [31:0]         next_len;

    // Only a final cycle may be overlapped by a new instruction
    assign op_ready = (state == isq_pkg::ST_IDLE) || (state == isq_pkg::ST_DATA)
                   || (state == isq_pkg::ST_SH2) || (state == isq_pkg::ST_BR3);
    assign take = op_valid && op_ready;
    assign is_branch = (op_class == isq_pkg::OP_BRANCH) || (op_class == isq_pkg::OP_EXCH)
                    || (op_class == isq_pkg::OP_LBL_LO);
    // Status transfers and compares never redirect the pc
    assign wpc = op_writes_pc && !op_compare && (op_class != isq_pkg::OP_PSR);

    // ************************************************************
    // Sequence
    // ************************************************************
    always_comb begin
        next_state = state;
        case (state)
            isq_pkg::ST_IDLE, isq_pkg::ST_DATA, isq_pkg::ST_SH2, isq_pkg::ST_BR3: begin
                if (!take) begin
                    next_state = isq_pkg::ST_IDLE;
                end else if (is_branch) begin
                    next_state = isq_pkg::ST_BR1;
                end else if (op_shift_reg && op_class != isq_pkg::OP_PSR) begin
                    next_state = isq_pkg::ST_SH1;
                end else if (wpc) begin
                    next_state = isq_pkg::ST_BR1;
                end else begin
                    next_state = isq_pkg::ST_DATA;
                end
            end
            isq_pkg::ST_SH1:  next_state = shpc_q ? isq_pkg::ST_SHPC : isq_pkg::ST_SH2;
            isq_pkg::ST_SHPC: next_state = isq_pkg::ST_BR2;
            isq_pkg::ST_BR1:  next_state = isq_pkg::ST_BR2;
            isq_pkg::ST_BR2:  next_state = isq_pkg::ST_BR3;
            default:          next_state = isq_pkg::ST_IDLE;
        endcase
    end

    // New state takes effect on the fetch from the target
    always_comb begin
        next_compact = compact_instr_state;
        if (next_state == isq_pkg::ST_BR2 && exch_q) begin
            next_compact = tgt_q[0] ? 1'b1 : 1'b0;
        end
    end

    // ************************************************************
    // Bus cycle row for the cycle about to start
    // ************************************************************
    always_comb begin
        next_len = instr_len(next_compact);
        next_addr = addr;
        next_fetch_n = 1'b1;
        next_request_n = 1'b1;
        next_sequential = 1'b0;
        case (next_state)
            isq_pkg::ST_DATA: begin
                next_addr = op_pc + {next_len[30:0], 1'b0};
                next_fetch_n = 1'b0;
                next_request_n = 1'b0;
                next_sequential = 1'b1;
            end
            isq_pkg::ST_BR1: begin
                next_addr = op_pc + {next_len[30:0], 1'b0};
                next_fetch_n = 1'b0;
                next_request_n = 1'b0;
                next_sequential = 1'b0;
            end
            isq_pkg::ST_SH1: begin
                next_addr = op_pc + {next_len[30:0], 1'b0};
                next_fetch_n = 1'b0;
                next_request_n = 1'b1;
                next_sequential = 1'b0;
            end
            isq_pkg::ST_SH2, isq_pkg::ST_SHPC: begin
                // Address held so the memory side may merge the cycles
                next_addr = pc_q + {next_len[30:0], 1'b0} + next_len;
                next_request_n = 1'b0;
                next_sequential = (next_state == isq_pkg::ST_SH2);
            end
            isq_pkg::ST_BR2: begin
                next_addr = exch_q ? {tgt_q[31:1], 1'b0} : tgt_q;
                next_fetch_n = 1'b0;
                next_request_n = 1'b0;
                next_sequential = 1'b1;
            end
            isq_pkg::ST_BR3: begin
                next_addr = addr + next_len;
                next_fetch_n = 1'b0;
                next_request_n = 1'b0;
                next_sequential = 1'b1;
            end
            default: begin
                next_addr = addr;
            end
        endcase
    end

    // ************************************************************
    // State and operand capture
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= isq_pkg::ST_IDLE;
            compact_instr_state <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            compact_instr_state <= next_compact;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cls_q <= isq_pkg::OP_DATA;
            pc_q <= 32'h0000_0000;
            tgt_q <= 32'h0000_0000;
            off_q <= 32'h0000_0000;
            link_q <= 1'b0;
            exch_q <= 1'b0;
            shpc_q <= 1'b0;
            cmp_q <= 1'b0;
        end else if (ce && take) begin
            cls_q <= isq_pkg::isq_op_t'(op_class);
            pc_q <= op_pc;
            tgt_q <= op_alu;
            off_q <= op_offset;
            // Second half of the long link always links, whatever the link input says
            link_q <= (op_link && (op_class != isq_pkg::OP_EXCH))
                   || (op_class == isq_pkg::OP_LBL_LO);
            exch_q <= (op_class == isq_pkg::OP_EXCH);
            shpc_q <= wpc && !compact_instr_state;
            cmp_q <= op_compare;
        end
    end

    // ************************************************************
    // Bus outputs, registered ahead of their cycle
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            addr <= 32'h0000_0000;
            access_size <= isq_pkg::SIZE_WORD;
            write_not_read <= 1'b0;
            instr_fetch_n <= 1'b1;
            translate_user_n <= 1'b0;
            compact_state_flag <= 1'b0;
            mem_request_n <= 1'b1;
            sequential_next <= 1'b0;
        end else if (ce) begin
            addr <= next_addr;
            access_size <= fetch_size(next_compact);
            write_not_read <= 1'b0;
            instr_fetch_n <= next_fetch_n;
            translate_user_n <= translate_in;
            compact_state_flag <= next_compact;
            mem_request_n <= next_request_n;
            sequential_next <= next_sequential;
        end
    end

    // ************************************************************
    // Link register, shifter latch and pipeline control
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            link_register <= 32'h0000_0000;
        end else if (ce) begin
            if (state == isq_pkg::ST_DATA && cls_q == isq_pkg::OP_LBL_HI) begin
                link_register <= pc_q + off_q;
            end else if (state == isq_pkg::ST_BR2 && link_q) begin
                link_register <= pc_q + (instr_len(compact_instr_state) << 1);
            end else if (state == isq_pkg::ST_BR3 && link_q) begin
                link_register <= link_register - instr_len(compact_instr_state);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            shift_amount <= 8'h00;
        end else if (ce && state == isq_pkg::ST_SH1) begin
            shift_amount <= shift_src[isq_pkg::SHIFT_W-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            result_write_en <= 1'b0;
            pipe_flush <= 1'b0;
            exc_lockout <= 1'b0;
        end else if (ce) begin
            result_write_en <= (next_state == isq_pkg::ST_DATA && !op_compare)
                            || (next_state == isq_pkg::ST_SH2 && !cmp_q);
            pipe_flush <= (next_state == isq_pkg::ST_BR2);
            exc_lockout <= (next_state == isq_pkg::ST_BR2)
                        || (next_state == isq_pkg::ST_BR3);
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    chk_fetch_size: assert property (
        !instr_fetch_n |-> access_size == fetch_size(compact_state_flag))
        else $error("fetch size does not match state");
    chk_data_row: assert property (
        state == isq_pkg::ST_DATA |-> !mem_request_n && sequential_next && !instr_fetch_n)
        else $error("data cycle row wrong");
    chk_branch_row: assert property (
        state == isq_pkg::ST_BR1 |-> !mem_request_n && !sequential_next
            && !write_not_read && addr == pc_q + (instr_len(compact_state_flag) << 1))
        else $error("branch first cycle row wrong");
    chk_branch_steps: assert property (
        state == isq_pkg::ST_BR2 && ce |=> state == isq_pkg::ST_BR3 && sequential_next)
        else $error("branch does not reach third cycle");
    chk_refill_addr: assert property (
        state == isq_pkg::ST_BR3 |-> addr == {tgt_q[31:1], tgt_q[0] && !exch_q}
            + instr_len(compact_state_flag))
        else $error("refill address wrong");
    chk_link_adjust: assert property (
        state == isq_pkg::ST_BR3 && link_q && ce
            |=> link_register == $past(link_register) - instr_len($past(compact_instr_state)))
        else $error("link adjust wrong");
    chk_shift_internal: assert property (
        state == isq_pkg::ST_SH1 |-> mem_request_n && !sequential_next && !instr_fetch_n)
        else $error("register shift first cycle not announcing internal");
    chk_compare_nowr: assert property (
        state == isq_pkg::ST_DATA && cmp_q |-> !result_write_en)
        else $error("compare wrote a destination");
    // The last refill cycle may already take the next instruction
    chk_refill_lock: assert property (
        (state == isq_pkg::ST_BR2 || state == isq_pkg::ST_BR3) |-> exc_lockout
            && (state == isq_pkg::ST_BR3 || !op_ready))
        else $error("exceptions not locked during refill");
    chk_exchange_state: assert property (
        state == isq_pkg::ST_BR1 && exch_q && ce
            |=> compact_state_flag == $past(tgt_q[0]))
        else $error("exchange state not applied");
    chk_long_link: assert property (
        state == isq_pkg::ST_DATA && cls_q == isq_pkg::OP_LBL_HI && ce
            |=> link_register == $past(pc_q) + $past(off_q))
        else $error("long link first half did not load the link");
    chk_shpc_row: assert property (
        state == isq_pkg::ST_SHPC |-> !mem_request_n && !sequential_next && instr_fetch_n
            && addr == pc_q + isq_pkg::LEN_WORD + isq_pkg::LEN_WORD + isq_pkg::LEN_WORD)
        else $error("shifted pc write second cycle row wrong");
    chk_flush_target: assert property (
        state == isq_pkg::ST_BR2 |-> pipe_flush && !instr_fetch_n && !mem_request_n)
        else $error("pipeline not flushed on target fetch");

    cov_branch_link: cover property (state == isq_pkg::ST_BR3 && link_q);
    cov_shift_pc: cover property (state == isq_pkg::ST_SHPC);
    cov_exchange_flip: cover property (state == isq_pkg::ST_BR2 && exch_q && compact_state_flag);
    cov_long_hi: cover property (state == isq_pkg::ST_DATA && cls_q == isq_pkg::OP_LBL_HI);

endmodule // isq_sequencer

`default_nettype wire

// >>> dv/isq_mem_model.sv
`timescale 1ns/10ps
`default_nettype none

module isq_mem_model (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        mem_request_n,
    input  wire logic        sequential_next,
    input  wire logic [31:0] addr,
    output logic [31:0]      merges
);
    // ****************************************
    // Memory side bookkeeping
    // ****************************************
    logic [1:0]  kind_q;
    logic [31:0] addr_q;
    logic        pend;

    // Internal cycle followed by a sequential access at the same address
    // becomes one access, so the model counts each such merge
    always_ff @(posedge mclk) begin
        if (rst) begin
            kind_q <= 2'h0;
            addr_q <= 32'h0;
            pend   <= 1'h0;
            merges <= 32'h0;
        end else begin
            kind_q <= {mem_request_n, sequential_next};
            addr_q <= addr;
            pend   <= (kind_q == 2'h2) && !mem_request_n && sequential_next;
            if (pend && addr == addr_q) begin
                merges <= merges + 32'h1;
            end
        end
    end
endmodule // isq_mem_model

`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic        mclk         = 1'h0;
    logic        rst          = 1'h1;
    logic        ce           = 1'h1;
    logic        op_valid     = 1'h0;
    logic [2:0]  op_class     = 3'h0;
    logic        op_link      = 1'h0;
    logic        op_shift_reg = 1'h0;
    logic        op_writes_pc = 1'h0;
    logic        op_compare   = 1'h0;
    logic [31:0] op_pc        = 32'h0;
    logic [31:0] op_alu       = 32'h0;
    logic [31:0] op_offset    = 32'h1000;
    logic [31:0] shift_src    = 32'h1234_56a5;
    logic        translate_in = 1'h1;
    logic        op_ready;
    logic [31:0] addr;
    logic [1:0]  access_size;
    logic        write_not_read;
    logic        instr_fetch_n;
    logic        translate_user_n;
    logic        compact_state_flag;
    logic        mem_request_n;
    logic        sequential_next;
    logic [31:0] link_register;
    logic [7:0]  shift_amount;
    logic        result_write_en;
    logic        pipe_flush;
    logic        exc_lockout;
    logic [31:0] merges;
    int          n_errors    = 0;
    int          checks_done = 0;

    always #50 mclk = ~mclk;

    isq_sequencer dut (
        .mclk(mclk), .rst(rst), .ce(ce), .op_valid(op_valid), .op_class(op_class),
        .op_link(op_link), .op_shift_reg(op_shift_reg), .op_writes_pc(op_writes_pc),
        .op_compare(op_compare), .op_pc(op_pc), .op_alu(op_alu), .op_offset(op_offset),
        .shift_src(shift_src), .translate_in(translate_in), .op_ready(op_ready),
        .addr(addr), .access_size(access_size), .write_not_read(write_not_read),
        .instr_fetch_n(instr_fetch_n), .translate_user_n(translate_user_n),
        .compact_state_flag(compact_state_flag), .mem_request_n(mem_request_n),
        .sequential_next(sequential_next), .link_register(link_register),
        .shift_amount(shift_amount), .result_write_en(result_write_en),
        .pipe_flush(pipe_flush), .exc_lockout(exc_lockout)
    );

    isq_mem_model mem (
        .mclk(mclk), .rst(rst), .mem_request_n(mem_request_n),
        .sequential_next(sequential_next), .addr(addr), .merges(merges)
    );

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic give_verdict;
        if (n_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [41:0] got, input logic [41:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [41:0] rowv();
        return {addr, access_size, compact_state_flag, mem_request_n, sequential_next,
                instr_fetch_n, pipe_flush, exc_lockout, write_not_read, translate_user_n};
    endfunction

    // Keep the strobe up when the next op follows back to back
    task automatic row(input logic [31:0] a, input logic [1:0] sz, input logic fl,
                       input logic [2:0] mqf, input logic [1:0] fx, input bit keep = 1'b0);
        @(negedge mclk);
        if (!keep) begin
            op_valid = 1'h0;
        end
        cmp(rowv(), {a, sz, fl, mqf, fx, 2'h1});
    endtask

    task automatic issue(input logic [2:0] cls, input logic lk, sr, wp, cm,
                         input logic [31:0] pc, alu);
        int k;
        k = 0;
        // A released strobe gets one idle edge before the next offer
        if (op_valid !== 1'h1) begin
            @(negedge mclk);
        end
        {op_valid, op_class, op_link, op_shift_reg, op_writes_pc, op_compare} =
            {1'h1, cls, lk, sr, wp, cm};
        op_pc = pc;
        op_alu = alu;
        while (op_ready !== 1'h1) begin
            k++;
            if (k > 8) begin
                n_errors++;
                give_verdict();
            end
            @(negedge mclk);
        end
        @(posedge mclk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_data;
        for (int i = 0; i < 3; i++) begin
            issue(i == 2 ? isq_pkg::OP_PSR : isq_pkg::OP_DATA, 1'h0, 1'h0, i == 2, i == 1,
                  32'h100 + 32'(i * 4), 32'h0);
            row(32'h108 + 32'(i * 4), 2'h2, 1'h0, 3'h2, 2'h0, i < 2);
            if (i < 2) cmp(42'(result_write_en), 42'(i != 1));
        end
    endtask

    task automatic t_data_pc;
        issue(isq_pkg::OP_DATA, 1'h0, 1'h0, 1'h1, 1'h0, 32'h2000, 32'h3000);
        row(32'h2008, 2'h2, 1'h0, 3'h0, 2'h0);
        row(32'h3000, 2'h2, 1'h0, 3'h2, 2'h3);
        cmp(42'(op_ready), 42'h0);
        row(32'h3004, 2'h2, 1'h0, 3'h2, 2'h1);
    endtask

    task automatic t_branch;
        issue(isq_pkg::OP_BRANCH, 1'h1, 1'h0, 1'h0, 1'h0, 32'h1000, 32'h2000);
        row(32'h1008, 2'h2, 1'h0, 3'h0, 2'h0);
        row(32'h2000, 2'h2, 1'h0, 3'h2, 2'h3);
        row(32'h2004, 2'h2, 1'h0, 3'h2, 2'h1);
        cmp(42'(link_register), 42'(32'h1008));
        @(negedge mclk);
        cmp(42'(link_register), 42'(32'h1004));
    endtask

    task automatic t_shift;
        logic [31:0] m0;
        m0 = merges;
        issue(isq_pkg::OP_DATA, 1'h0, 1'h1, 1'h0, 1'h0, 32'h4000, 32'h0);
        row(32'h4008, 2'h2, 1'h0, 3'h4, 2'h0);
        row(32'h400c, 2'h2, 1'h0, 3'h3, 2'h0);
        cmp(42'(shift_amount), 42'(8'ha5));
        repeat (2) @(negedge mclk);
        cmp(42'(merges), 42'(m0 + 32'h1));
    endtask

    // Clock enable frozen for one cycle in the middle of the sequence
    task automatic t_shift_pc;
        issue(isq_pkg::OP_DATA, 1'h0, 1'h1, 1'h1, 1'h0, 32'h5000, 32'h6000);
        row(32'h5008, 2'h2, 1'h0, 3'h4, 2'h0);
        ce = 1'h0;
        row(32'h5008, 2'h2, 1'h0, 3'h4, 2'h0);
        ce = 1'h1;
        row(32'h500c, 2'h2, 1'h0, 3'h1, 2'h0);
        row(32'h6000, 2'h2, 1'h0, 3'h2, 2'h3);
        row(32'h6004, 2'h2, 1'h0, 3'h2, 2'h1);
    endtask

    task automatic t_exchange(input logic [31:0] pc, input logic [31:0] alu, input logic old);
        logic [31:0] tgt;
        tgt = {alu[31:1], 1'h0};
        issue(isq_pkg::OP_EXCH, 1'h0, 1'h0, 1'h0, 1'h0, pc, alu);
        row(pc + (old ? 32'h4 : 32'h8), old ? 2'h1 : 2'h2, old, 3'h0, 2'h0);
        row(tgt, alu[0] ? 2'h1 : 2'h2, alu[0], 3'h2, 2'h3);
        row(tgt + (alu[0] ? 32'h2 : 32'h4), alu[0] ? 2'h1 : 2'h2, alu[0], 3'h2, 2'h1);
    endtask

    task automatic t_compact;
        issue(isq_pkg::OP_DATA, 1'h0, 1'h0, 1'h0, 1'h0, 32'h200, 32'h0);
        row(32'h204, 2'h1, 1'h1, 3'h2, 2'h0);
        issue(isq_pkg::OP_LBL_HI, 1'h0, 1'h0, 1'h0, 1'h0, 32'h300, 32'h0);
        row(32'h304, 2'h1, 1'h1, 3'h2, 2'h0, 1'b1);
        issue(isq_pkg::OP_LBL_LO, 1'h0, 1'h0, 1'h0, 1'h0, 32'h302, 32'h500);
        row(32'h306, 2'h1, 1'h1, 3'h0, 2'h0);
        cmp(42'(link_register), 42'(32'h1300));
        row(32'h500, 2'h1, 1'h1, 3'h2, 2'h3);
        row(32'h502, 2'h1, 1'h1, 3'h2, 2'h1);
        cmp(42'(link_register), 42'(32'h306));
        @(negedge mclk);
        cmp(42'(link_register), 42'(32'h304));
    endtask

    initial begin
        repeat (3) @(negedge mclk);
        cmp(rowv(), {32'h0, 2'h2, 1'h0, 3'h5, 4'h0});
        cmp({2'h0, link_register, shift_amount}, 42'h0);
        repeat (5) @(negedge mclk);
        rst = 1'h0;
        t_data();
        t_data_pc();
        t_branch();
        t_shift();
        t_shift_pc();
        t_exchange(32'h800, 32'h201, 1'h0);
        t_compact();
        t_exchange(32'h400, 32'h300, 1'h1);
        give_verdict();
    end
endmodule // tb_top

`default_nettype wire
